// >>> hdl/dcc_dispatch_completion.sv
`timescale 1ns/1ps
module dcc_dispatch_completion (
  // clock and reset
  input  wire logic               ref_clk_in,
  input  wire logic               srst_in,
  // dispatch slots zero and one, bit n is slot n
  input  wire logic [1:0]         slot_vld_in,
  input  wire dcc_pkg::dcc_unit_e slot0_unit_in,
  input  wire dcc_pkg::dcc_unit_e slot1_unit_in,
  input  wire logic [1:0]         slot_int_dst_in,
  input  wire logic [1:0]         slot_ld_upd_in,
  input  wire logic [1:0]         slot_fp_dst_in,
  input  wire logic [1:0]         slot0_cr_upd_in,
  input  wire logic [1:0]         slot1_cr_upd_in,
  input  wire logic [1:0]         slot_int_ld_in,
  input  wire logic [1:0]         slot_cser_in,
  input  wire logic [1:0]         slot_rser_in,
  input  wire dcc_pkg::dcc_cnt_t  iq_occ_in,
  input  wire logic [5:0]         unit_free_in,
  // dispatch answer
  output logic [1:0]              dispatch_out,
  output dcc_pkg::dcc_idx_t       disp_tag0_out,
  output dcc_pkg::dcc_idx_t       disp_tag1_out,
  // finish reports from the execution units
  input  wire logic [1:0]         finish_vld_in,
  input  wire dcc_pkg::dcc_idx_t  finish_tag0_in,
  input  wire dcc_pkg::dcc_idx_t  finish_tag1_in,
  input  wire logic [1:0]         finish_exc_in,
  // branch unit
  input  wire logic               br_vld_in,
  input  wire dcc_pkg::dcc_br_e   br_kind_in,
  input  wire logic               link_register_avail_in,
  input  wire logic               count_register_avail_in,
  input  wire logic               shadow_link_avail_in,
  input  wire logic               cond_known_in,
  input  wire logic               cond_false_in,
  input  wire logic               cr_resolve_in,
  input  wire logic               flush_in,
  output logic                    fetch_stall_out,
  output logic                    br_fold_out,
  output logic                    exec_hold_out,
  output logic                    pred_unres_out,
  // completion
  output logic [1:0]              retire_out,
  output logic                    head_exc_out,
  output dcc_pkg::dcc_cnt_t       cq_count_out,
  output dcc_pkg::dcc_cnt_t       inflight_out,
  output dcc_pkg::dcc_cnt_t       int_free_out,
  output dcc_pkg::dcc_cnt_t       fp_free_out
);
  import dcc_pkg::*;

  // --------------------------------------------------------------------------
  // helper functions
  // --------------------------------------------------------------------------

  // advance a completion index around the six slots
  function automatic dcc_idx_t dcc_wrap(input dcc_idx_t idx, input dcc_cnt_t add);
    logic [4:0] s;
    s = {2'h0, idx} + {1'b0, add};
    if (s >= {1'b0, DCC_CQ_DEPTH}) begin
      s = s - {1'b0, DCC_CQ_DEPTH};
    end
    return s[2:0];
  endfunction : dcc_wrap

  // distance of a slot from the head
  function automatic dcc_cnt_t dcc_dist(input dcc_idx_t idx, input dcc_idx_t head);
    dcc_cnt_t d;
    d = (idx >= head) ? ({1'b0, idx} - {1'b0, head}) : ({1'b0, idx} + DCC_CQ_DEPTH - {1'b0, head});
    return d;
  endfunction : dcc_dist

  // integer destinations one instruction asks for
  function automatic logic [1:0] dcc_int_need(input logic dst, input logic ldu);
    return ldu ? DCC_LDU_INT_DST : (dst ? DCC_ONE_INT_DST : DCC_NO_DST);
  endfunction : dcc_int_need

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  dcc_idx_t   head_r;                    // oldest completion slot
  dcc_cnt_t   count_r;                   // occupied completion slots
  logic       pred_unres_r;              // a predicted branch awaits its condition
  logic [5:0] fin_r;                     // entry finished
  logic [5:0] exc_r;                     // entry raised an exception
  logic [5:0] spec_r;                    // entry follows an unresolved prediction
  logic [5:0] cser_r;                    // entry is completion-serialized
  logic [5:0] intld_r;                   // entry is integer or load
  logic [1:0] intu_r [6];                // integer updates per entry
  logic [1:0] fpu_r  [6];                // floating updates per entry
  logic [1:0] cru_r  [6];                // condition register updates per entry
  logic [5:0] occ;                       // entry holds a live instruction

  // --------------------------------------------------------------------------
  // dispatch decode
  // --------------------------------------------------------------------------
  wire dcc_cnt_t   int_free;             // integer renames free
  wire dcc_cnt_t   fp_free;              // floating renames free
  wire logic [1:0] need0 = dcc_int_need(slot_int_dst_in[0], slot_ld_upd_in[0]);
  wire logic [1:0] need1 = dcc_int_need(slot_int_dst_in[1], slot_ld_upd_in[1]);
  wire dcc_cnt_t   need0_c = {2'h0, need0};
  wire dcc_cnt_t   need01_c = {2'h0, need0} + {2'h0, need1};
  wire dcc_cnt_t   fp0_c = {3'h0, slot_fp_dst_in[0]};
  wire dcc_cnt_t   fp01_c = {3'h0, slot_fp_dst_in[0]} + {3'h0, slot_fp_dst_in[1]};
  wire dcc_cnt_t   cq_free = DCC_CQ_DEPTH - count_r;
  wire logic       cser_busy = |(occ & cser_r & ~fin_r);
  // the two integer units are separate entries, so a pair shares no unit
  wire logic       unit_ok0 = (slot0_unit_in == DCC_U_NONE) | unit_free_in[slot0_unit_in];
  wire logic       unit_ok1 = (slot1_unit_in == DCC_U_NONE)
                             | (unit_free_in[slot1_unit_in] & (slot1_unit_in != slot0_unit_in));

  wire logic disp0 = slot_vld_in[0] & unit_ok0 & (int_free >= need0_c) & (fp_free >= fp0_c)
                   & (cq_free >= DCC_ONE) & ~cser_busy;
  wire logic disp1 = disp0 & ~slot_cser_in[0] & ~slot_rser_in[0] & slot_vld_in[1] & unit_ok1
                   & (int_free >= need01_c) & (fp_free >= fp01_c) & (cq_free >= DCC_TWO);
  wire dcc_cnt_t disp_cnt = {3'h0, disp0} + {3'h0, disp1};
  wire dcc_cnt_t int_take = disp1 ? need01_c : (disp0 ? need0_c : DCC_COUNT_RST);  // integer renames taken now
  wire dcc_idx_t tail0 = dcc_wrap(head_r, count_r);
  wire dcc_idx_t tail1 = dcc_wrap(head_r, count_r + DCC_ONE);

  assign dispatch_out  = {disp1, disp0};
  assign disp_tag0_out = tail0;
  assign disp_tag1_out = tail1;

  // --------------------------------------------------------------------------
  // completion decode
  // --------------------------------------------------------------------------
  wire dcc_idx_t h1 = dcc_wrap(head_r, DCC_ONE);
  wire logic ok0 = (count_r >= DCC_ONE) & fin_r[head_r] & ~spec_r[head_r] & ~exc_r[head_r];
  wire dcc_cnt_t cr_sum  = {2'h0, cru_r[head_r]} + {2'h0, cru_r[h1]};
  wire dcc_cnt_t int_sum = {2'h0, intu_r[head_r]} + {2'h0, intu_r[h1]};
  wire dcc_cnt_t fp_sum  = {2'h0, fpu_r[head_r]} + {2'h0, fpu_r[h1]};
  wire logic ok1 = ok0 & (count_r >= DCC_TWO) & fin_r[h1] & ~spec_r[h1] & ~exc_r[h1] & intld_r[h1]
                 & (cr_sum <= DCC_MAX_UPD) & (int_sum <= DCC_MAX_UPD) & (fp_sum <= DCC_MAX_UPD);
  wire dcc_cnt_t ret_cnt = {3'h0, ok0} + {3'h0, ok1};
  wire dcc_cnt_t int_rel = (ok0 ? {2'h0, intu_r[head_r]} : DCC_COUNT_RST)
                         + (ok1 ? {2'h0, intu_r[h1]} : DCC_COUNT_RST);
  wire dcc_cnt_t fp_rel  = (ok0 ? {2'h0, fpu_r[head_r]} : DCC_COUNT_RST)
                         + (ok1 ? {2'h0, fpu_r[h1]} : DCC_COUNT_RST);

  assign retire_out   = {ok1, ok0};
  // an excepting head never retires here; the exception path flushes
  assign head_exc_out = (count_r >= DCC_ONE) & fin_r[head_r] & exc_r[head_r];
  assign cq_count_out = count_r;
  assign inflight_out = count_r + iq_occ_in;
  assign int_free_out = int_free;
  assign fp_free_out  = fp_free;

  // --------------------------------------------------------------------------
  // branch resolution
  // --------------------------------------------------------------------------
  // resource needs
  wire logic br_ok = (br_kind_in == DCC_B_TO_LINK)  ? link_register_avail_in :
                     (br_kind_in == DCC_B_TO_COUNT) ? count_register_avail_in :
                     (br_kind_in == DCC_B_AND_LINK) ? shadow_link_avail_in :
                     (br_kind_in == DCC_B_CTR_COND) ? (count_register_avail_in | cond_false_in) :
                     (br_kind_in == DCC_B_COND)     ? ~pred_unres_r : 1'b1;
  wire logic br_cond = (br_kind_in == DCC_B_COND) | (br_kind_in == DCC_B_CTR_COND);
  // a conditional branch folded before its condition is known becomes a prediction
  wire logic pred_set = br_vld_in & br_ok & br_cond & ~cond_known_in;

  assign fetch_stall_out = br_vld_in & ~br_ok;
  assign br_fold_out     = br_vld_in & br_ok;
  // hold younger work at a second branch
  assign exec_hold_out   = br_vld_in & pred_unres_r;
  assign pred_unres_out  = pred_unres_r;

  // prediction flag: a new prediction wins over resolution, a squash wins over both
  always_ff @(posedge ref_clk_in) begin
    if (srst_in | flush_in) begin
      pred_unres_r <= DCC_FLAG_RST;
    end else begin
      pred_unres_r <= pred_set | (pred_unres_r & ~cr_resolve_in);
    end
  end

  // --------------------------------------------------------------------------
  // completion slots
  // --------------------------------------------------------------------------
  // head and occupancy; flush empties the slots but keeps the head
  // count held within six
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      head_r  <= DCC_HEAD_RST;
      count_r <= DCC_COUNT_RST;
    end else if (flush_in) begin
      count_r <= DCC_COUNT_RST;
    end else begin
      head_r  <= dcc_wrap(head_r, ret_cnt);
      count_r <= count_r + disp_cnt - ret_cnt;
    end
  end

  // one set of flags per slot
  for (genvar i = 0; i < 6; i++) begin : g_slot
    wire dcc_idx_t me  = dcc_idx_t'(i);
    wire logic     wr0 = disp0 & (tail0 == me);
    wire logic     wr1 = disp1 & (tail1 == me);
    wire logic     f0  = finish_vld_in[0] & (finish_tag0_in == me);
    wire logic     f1  = finish_vld_in[1] & (finish_tag1_in == me);
    assign occ[i] = dcc_dist(me, head_r) < count_r;

    // status flags; a finish report sets fin, and exc when it flags an exception; a new dispatch, a flush or reset clears them
    always_ff @(posedge ref_clk_in) begin
      if (srst_in | flush_in) begin
        fin_r[i]  <= DCC_FLAG_RST;
        exc_r[i]  <= DCC_FLAG_RST;
        spec_r[i] <= DCC_FLAG_RST;
      end else if (wr0 | wr1) begin
        fin_r[i]  <= DCC_FLAG_RST;
        exc_r[i]  <= DCC_FLAG_RST;
        spec_r[i] <= pred_unres_r;
      end else begin
        fin_r[i]  <= fin_r[i] | f0 | f1;
        exc_r[i]  <= exc_r[i] | (f0 & finish_exc_in[0]) | (f1 & finish_exc_in[1]);
        spec_r[i] <= spec_r[i] & ~cr_resolve_in;
      end
    end

    // instruction attributes captured at dispatch
    always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
        cser_r[i]  <= DCC_FLAG_RST;
        intld_r[i] <= DCC_FLAG_RST;
        intu_r[i]  <= DCC_NO_DST;
        fpu_r[i]   <= DCC_NO_DST;
        cru_r[i]   <= DCC_NO_DST;
      end else if (wr0) begin
        cser_r[i]  <= slot_cser_in[0];
        intld_r[i] <= slot_int_ld_in[0];
        intu_r[i]  <= need0;
        fpu_r[i]   <= {1'b0, slot_fp_dst_in[0]};
        cru_r[i]   <= slot0_cr_upd_in;
      end else if (wr1) begin
        cser_r[i]  <= slot_cser_in[1];
        intld_r[i] <= slot_int_ld_in[1];
        intu_r[i]  <= need1;
        fpu_r[i]   <= {1'b0, slot_fp_dst_in[1]};
        cru_r[i]   <= slot1_cr_upd_in;
      end
    end
  end

  // --------------------------------------------------------------------------
  // rename pools
  // --------------------------------------------------------------------------
  // integer renames taken at dispatch
  dcc_rename_pool #(.SIZE(DCC_INT_RENAMES)) u_int_pool (
    .ref_clk_in (ref_clk_in),
    .srst_in    (srst_in),
    .flush_in   (flush_in),
    .take_in    (int_take),
    .rel_in     (int_rel),
    .free_out   (int_free)
  );

  dcc_rename_pool #(.SIZE(DCC_FP_RENAMES)) u_fp_pool (
    .ref_clk_in (ref_clk_in),
    .srst_in    (srst_in),
    .flush_in   (flush_in),
    .take_in    (disp1 ? fp01_c : (disp0 ? fp0_c : DCC_COUNT_RST)),
    .rel_in     (fp_rel),
    .free_out   (fp_free)
  );

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);

  peak_rate_a: assert property (disp_cnt + {3'h0, br_fold_out} <= DCC_PEAK_IPC)
    else $error("more than three instructions handled in one cycle");
  slot_one_pair_a: assert property (disp1 |-> disp0 && !slot_cser_in[0] && !slot_rser_in[0])
    else $error("slot one dispatched without a clean slot zero");
  cq_bound_a: assert property (count_r <= DCC_CQ_DEPTH)
    else $error("completion slots overfilled");
  slot_zero_gate_a: assert property (disp0 |-> !cser_busy && count_r < DCC_CQ_DEPTH && int_free >= need0_c)
    else $error("slot zero dispatched without resources");
  slot_one_res_a: assert property (disp1 |-> int_free >= need01_c && fp_free >= fp01_c)
    else $error("slot one used resources already taken");
  ldu_two_a: assert property (disp0 && slot_ld_upd_in[0] && !flush_in |-> need0 == DCC_LDU_INT_DST ##1 int_free == $past(int_free) + $past(int_rel) - $past(int_take))
    else $error("load with update did not take two integer renames");
  head_retire_a: assert property (retire_out[0] |-> fin_r[head_r] && !spec_r[head_r] && !exc_r[head_r])
    else $error("head retired while not ready");
  pair_retire_a: assert property (retire_out[1] |-> retire_out[0] && intld_r[h1] && fin_r[h1])
    else $error("second entry retired illegally");
  upd_limit_a: assert property (retire_out[1] |-> cr_sum <= DCC_MAX_UPD && int_sum <= DCC_MAX_UPD)
    else $error("dual retire exceeded update limit");
  inflight_a: assert property (iq_occ_in <= DCC_CQ_DEPTH |-> inflight_out <= DCC_MAX_INFLIGHT)
    else $error("more than twelve instructions in flight");
  link_stall_a: assert property (br_vld_in && br_kind_in == DCC_B_TO_LINK && !link_register_avail_in |-> fetch_stall_out)
    else $error("link branch did not stall");
  shadow_stall_a: assert property (br_vld_in && br_kind_in == DCC_B_AND_LINK |-> fetch_stall_out == !shadow_link_avail_in)
    else $error("branch and link stall wrong");
  cond_wait_a: assert property (br_vld_in && br_kind_in == DCC_B_COND && pred_unres_r |-> fetch_stall_out && exec_hold_out)
    else $error("condition branch passed a prediction");
  release_a: assert property (!flush_in |=> count_r == $past(count_r) + $past(disp_cnt) - $past(ret_cnt))
    else $error("completion slots not released at retire");

  dual_disp_c: cover property (dispatch_out == 2'h3);
  dual_ret_c: cover property (retire_out == 2'h3);
  stall_c: cover property (fetch_stall_out ##1 br_fold_out);

endmodule : dcc_dispatch_completion

// >>> hdl/dcc_pkg.sv
// ----------------------------------------------------------------------------
// dispatch and completion control constants
// ----------------------------------------------------------------------------
package dcc_pkg;

  // count type wide enough for the in-flight total
  typedef logic [3:0] dcc_cnt_t;
  // completion slot index
  typedef logic [2:0] dcc_idx_t;

  // throughput and capacity figures
  localparam dcc_cnt_t DCC_PEAK_IPC     = 4'h3;  // two dispatched plus one folded branch
  localparam dcc_cnt_t DCC_CQ_DEPTH     = 4'h6;  // completion slots
  localparam dcc_cnt_t DCC_INT_RENAMES  = 4'h6;  // integer rename registers
  localparam dcc_cnt_t DCC_FP_RENAMES   = 4'h6;  // floating rename registers
  localparam dcc_cnt_t DCC_MAX_INFLIGHT = 4'hC;  // completion head through sixth dispatch slot
  localparam dcc_cnt_t DCC_MAX_UPD      = 4'h2;  // per-type update limit on dual retire
  localparam dcc_cnt_t DCC_ONE          = 4'h1;
  localparam dcc_cnt_t DCC_TWO          = 4'h2;
  localparam int       DCC_UNITS        = 6;     // unit select width of the free vector

  // update counts per instruction
  localparam logic [1:0] DCC_LDU_INT_DST = 2'h2; // load with update writes two integer registers
  localparam logic [1:0] DCC_ONE_INT_DST = 2'h1;
  localparam logic [1:0] DCC_NO_DST      = 2'h0;

  // reset values
  localparam dcc_idx_t DCC_HEAD_RST  = 3'h0;
  localparam dcc_cnt_t DCC_COUNT_RST = 4'h0;
  localparam logic     DCC_FLAG_RST  = 1'b0;

  // execution unit selector; NONE goes to the completion slots only
  typedef enum logic [2:0] {
    DCC_U_NONE = 3'h0,
    DCC_U_IU1  = 3'h1,
    DCC_U_IU2  = 3'h2,
    DCC_U_FPU  = 3'h3,
    DCC_U_LSU  = 3'h4,
    DCC_U_SRU  = 3'h5
  } dcc_unit_e;

  // branch forms seen by the branch unit
  typedef enum logic [2:0] {
    DCC_B_PLAIN    = 3'h0,
    DCC_B_TO_LINK  = 3'h1,
    DCC_B_TO_COUNT = 3'h2,
    DCC_B_AND_LINK = 3'h3,
    DCC_B_CTR_COND = 3'h4,
    DCC_B_COND     = 3'h5
  } dcc_br_e;

endpackage : dcc_pkg

// >>> hdl/dcc_rename_pool.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// rename register free counter
// ----------------------------------------------------------------------------
module dcc_rename_pool #(
  parameter dcc_pkg::dcc_cnt_t SIZE = 4'h6
) (
  // clock and reset
  input  wire logic              ref_clk_in,
  input  wire logic              srst_in,
  // squash returns every register
  input  wire logic              flush_in,
  // registers taken at dispatch and given back at retire
  input  wire dcc_pkg::dcc_cnt_t take_in,
  input  wire dcc_pkg::dcc_cnt_t rel_in,
  // registers free now
  output dcc_pkg::dcc_cnt_t      free_out
);
  import dcc_pkg::*;

  dcc_cnt_t free_r;    // free registers
  dcc_cnt_t free_nxt;  // next free count

  // released registers only show next cycle, keeping the dispatch check off the retire path
  assign free_nxt = flush_in ? SIZE : (free_r - take_in + rel_in);
  assign free_out = free_r;

  // pool starts full
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      free_r <= SIZE;
    end else begin
      free_r <= free_nxt;
    end
  end

  // the pool never goes negative nor beyond its size
  pool_bound_a: assert property (@(posedge ref_clk_in) disable iff (srst_in) free_r <= SIZE)
    else $error("rename pool count out of range");

endmodule : dcc_rename_pool

// >>> verif/dcc_exec_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// execution unit stand-in: finishes dispatched work in any order
// ----------------------------------------------------------------------------
module dcc_exec_model (
  // clock, reset and finish chance in percent
  input  wire logic              ref_clk_in,
  input  wire logic              srst_in,
  input  wire logic [6:0]        fin_pct_in,
  // dispatch answer seen at the block
  input  wire logic [1:0]        disp_in,
  input  wire dcc_pkg::dcc_idx_t tag0_in,
  input  wire dcc_pkg::dcc_idx_t tag1_in,
  // finish reports, one cycle each
  output logic [1:0]             fin_vld_out,
  output dcc_pkg::dcc_idx_t      fin_tag0_out,
  output dcc_pkg::dcc_idx_t      fin_tag1_out
);
  import dcc_pkg::*;
  dcc_idx_t busy_q[$];  // dispatched but not yet finished
  initial begin
    fin_vld_out = 2'h0;
    fin_tag0_out = 3'h0;
    fin_tag1_out = 3'h0;
  end
  // record tags at the edge that takes the dispatch; reset drops them all
  always @(posedge ref_clk_in) begin
    if (srst_in) begin
      busy_q.delete();
    end else begin
      if (disp_in[0]) busy_q.push_back(tag0_in);
      if (disp_in[1]) busy_q.push_back(tag1_in);
    end
  end
  // pick random live tags; an idle tag lane flips so no stale copy lingers
  always @(negedge ref_clk_in) begin : finish_gen
    int k;
    logic [1:0] v;
    dcc_idx_t t [2];
    v = 2'h0;
    t[0] = ~fin_tag0_out;
    t[1] = ~fin_tag1_out;
    for (int n = 0; n < 2; n++) begin
      if (busy_q.size() > 0 && $urandom_range(99, 0) < fin_pct_in) begin
        k = $urandom_range(busy_q.size() - 1, 0);
        t[n] = busy_q[k];
        busy_q.delete(k);
        v[n] = 1'b1;
      end
    end
    fin_vld_out <= v;
    fin_tag0_out <= t[0];
    fin_tag1_out <= t[1];
  end
endmodule : dcc_exec_model

// >>> verif/tb.sv
`timescale 1ns/1ps
module tb;
  import dcc_pkg::*;
  localparam int CQ = DCC_CQ_DEPTH;
  localparam int RN = DCC_INT_RENAMES;
  localparam int FN = DCC_FP_RENAMES;
  logic       ref_clk_in, srst_in, disp_on, bvld, la, ca, sa, cf, stall, fold, hold, punres, hexc;
  logic [1:0] vld, idst, ldu, fpd, ild, rser, cser, cr0, cr1, disp, ret, fvld;
  logic [5:0] ufree;
  logic [6:0] fin_pct;
  dcc_unit_e  u0, u1;
  dcc_br_e    bkind;
  dcc_cnt_t   occ, cqc, infl, ifree, ffree;
  dcc_idx_t   t0, t1, ft0, ft1;
  int         error_cnt, check_count, i;
  // reference state, one record per completion slot
  int         r_head, r_cnt, r_if, r_ff;
  int         e_fin[6], e_int[6], e_fp[6], e_cr[6], e_ild[6], e_cs[6];
  dcc_dispatch_completion dcc_dispatch_completion_i (
    .ref_clk_in(ref_clk_in), .srst_in(srst_in), .slot_vld_in(vld), .slot0_unit_in(u0), .slot1_unit_in(u1),
    .slot_int_dst_in(idst), .slot_ld_upd_in(ldu), .slot_fp_dst_in(fpd), .slot0_cr_upd_in(cr0),
    .slot1_cr_upd_in(cr1), .slot_int_ld_in(ild), .slot_cser_in(cser), .slot_rser_in(rser), .iq_occ_in(occ),
    .unit_free_in(ufree), .dispatch_out(disp), .disp_tag0_out(t0), .disp_tag1_out(t1), .finish_vld_in(fvld),
    .finish_tag0_in(ft0), .finish_tag1_in(ft1), .finish_exc_in(2'h0), .br_vld_in(bvld), .br_kind_in(bkind),
    .link_register_avail_in(la), .count_register_avail_in(ca), .shadow_link_avail_in(sa),
    .cond_known_in(1'b1), .cond_false_in(cf), .cr_resolve_in(1'b0), .flush_in(1'b0), .fetch_stall_out(stall),
    .br_fold_out(fold), .exec_hold_out(hold), .pred_unres_out(punres), .retire_out(ret), .head_exc_out(hexc),
    .cq_count_out(cqc), .inflight_out(infl), .int_free_out(ifree), .fp_free_out(ffree));
  dcc_exec_model dcc_exec_model_i (
    .ref_clk_in(ref_clk_in), .srst_in(srst_in), .fin_pct_in(fin_pct), .disp_in(disp), .tag0_in(t0),
    .tag1_in(t1), .fin_vld_out(fvld), .fin_tag0_out(ft0), .fin_tag1_out(ft1));
  // compare helpers, one per kind of result
  task automatic chk_two(input logic [1:0] got, input logic [1:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk_two
  task automatic chk_cnt(input logic [3:0] got, input int exp);
    check_count++;
    if (got !== exp[3:0]) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp[3:0]);
    end
  endtask : chk_cnt
  // random slot and branch stimulus; load with update always has a destination
  task automatic drive;
    int o;
    logic [1:0] a;
    o = disp_on ? $urandom_range(6, 0) : 0;
    a = 2'($urandom);
    occ <= dcc_cnt_t'(o);
    vld <= {o > 1, o > 0};
    u0 <= dcc_unit_e'($urandom_range(5, 1));
    u1 <= dcc_unit_e'($urandom_range(5, 1));
    idst <= a;
    ldu <= a & 2'($urandom);
    fpd <= 2'($urandom);
    ild <= 2'($urandom);
    rser <= 2'($urandom);
    cser <= {$urandom_range(7, 0) == 0, $urandom_range(7, 0) == 0};
    cr0 <= 2'($urandom_range(2, 0));
    cr1 <= 2'($urandom_range(2, 0));
    ufree <= 6'($urandom | $urandom);
    bvld <= 1'($urandom);
    bkind <= dcc_br_e'($urandom_range(5, 0));
    {la, ca, sa, cf} <= 4'($urandom);
  endtask : drive
  // reference model: expected answers from the state before this edge
  always @(posedge ref_clk_in) begin : ref_model
    int n0, n1, h, e0;
    logic [1:0] dx, rx;
    logic sx, cb;
    cb = 1'b0;
    for (int k = 0; k < CQ; k++) if (((k - r_head + CQ) % CQ) < r_cnt && e_cs[k] == 1 && e_fin[k] == 0) cb = 1'b1;
    n0 = ldu[0] ? 2 : int'(idst[0]);
    n1 = ldu[1] ? 2 : int'(idst[1]);
    e0 = (r_head + r_cnt) % CQ;
    h = (r_head + 1) % CQ;
    dx[0] = vld[0] && ufree[u0] && n0 <= r_if && fpd[0] <= r_ff && r_cnt < CQ && !cb;
    dx[1] = dx[0] && vld[1] && !rser[0] && !cser[0] && u1 != u0 && ufree[u1] && n0 + n1 <= r_if
            && fpd[0] + fpd[1] <= r_ff && r_cnt < CQ - 1;
    rx[0] = r_cnt > 0 && e_fin[r_head] == 1;
    rx[1] = rx[0] && r_cnt > 1 && e_fin[h] == 1 && e_ild[h] == 1 && e_cr[r_head] + e_cr[h] <= 2
            && e_int[r_head] + e_int[h] <= 2 && e_fp[r_head] + e_fp[h] <= 2;
    case (bkind)
      DCC_B_TO_LINK:  sx = !la;
      DCC_B_TO_COUNT: sx = !ca;
      DCC_B_AND_LINK: sx = !sa;
      DCC_B_CTR_COND: sx = !(ca || cf);
      default:        sx = 1'b0;
    endcase
    if (!srst_in) begin
      chk_two(disp, dx);
      chk_two(ret, rx);
      chk_two({fold, stall}, {bvld & ~sx, bvld & sx});
      chk_two({hold, punres | hexc}, 2'h0);
      chk_cnt(cqc, r_cnt);
      chk_cnt(ifree, r_if);
      chk_cnt(ffree, r_ff);
      chk_cnt(infl, r_cnt + int'(occ));
      if (dx[0]) chk_cnt({1'b0, t0}, e0);
      if (dx[1]) chk_cnt({1'b0, t1}, (e0 + 1) % CQ);
    end
    if (srst_in) begin
      r_head = 0;
      r_cnt = 0;
      r_if = RN;
      r_ff = FN;
      e_fin = '{default: 0};
      e_cs = '{default: 0};
    end else begin
      // retiring slots give back their renames at this edge
      for (int k = 0; k < 2; k++) if (rx[k]) begin
        h = (r_head + k) % CQ;
        r_if += e_int[h];
        r_ff += e_fp[h];
        e_fin[h] = 0;
      end
      if (fvld[0]) e_fin[ft0] = 1;
      if (fvld[1]) e_fin[ft1] = 1;
      for (int k = 0; k < 2; k++) if (dx[k]) begin
        h = (e0 + k) % CQ;
        e_fin[h] = 0;
        e_int[h] = k ? n1 : n0;
        e_fp[h] = fpd[k];
        e_cr[h] = k ? cr1 : cr0;
        e_ild[h] = ild[k];
        e_cs[h] = cser[k];
        r_if -= e_int[h];
        r_ff -= e_fp[h];
      end
      r_head = (r_head + rx[0] + rx[1]) % CQ;
      r_cnt = r_cnt + dx[0] + dx[1] - rx[0] - rx[1];
    end
  end
  task automatic run(input int n, input logic [6:0] pct, input logic on);
    fin_pct <= pct;
    disp_on <= on;
    repeat (n) @(negedge ref_clk_in);
  endtask : run
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    ref_clk_in = 1'b0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end
  always @(negedge ref_clk_in) drive();
  // slow finishes fill the slots and renames, then mixed, mid-run reset, drain
  initial begin
    error_cnt = 0;
    check_count = 0;
    fin_pct = 7'h05;
    disp_on = 1'b1;
    srst_in = 1'b1;
    void'($urandom(40533));
    drive();
    repeat (6) @(negedge ref_clk_in);
    srst_in <= 1'b0;
    run(150, 7'h05, 1'b1);
    $display("test fill done");
    run(400, 7'h3C, 1'b1);
    $display("test mixed done");
    srst_in <= 1'b1;
    run(2, 7'h3C, 1'b1);
    srst_in <= 1'b0;
    run(100, 7'h28, 1'b1);
    $display("test mid reset done");
    run(2, 7'h64, 1'b0);
    for (i = 0; i < 60 && r_cnt != 0; i++) @(negedge ref_clk_in);
    if (r_cnt != 0) error_cnt++;
    chk_cnt(ifree, RN);
    chk_cnt(cqc, 0);
    $display("test drain done");
    wrap_up();
  end
endmodule : tb
